// [verilog/sas_sequencer.sv]
// module: converter sequencer top, register port, trigger, result path
// assumes an 8-bit peripheral port with one-cycle read and write strobes,
// a comparator and sample-and-hold outside, and standby as a same-clock level
`timescale 1ns/1ps
`default_nettype none
module sas_sequencer #(
    parameter int RES_BITS = 10,
    parameter int NUM_RESULTS = 4
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_standby,
    input wire logic [3:0] i_addr,
    input wire logic i_rd,
    input wire logic i_wr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata,
    input wire logic i_ext_trigger_n,
    input wire logic i_cmp_above,
    output logic o_sample_hold,
    output logic [2:0] o_chan,
    output logic [RES_BITS-1:0] o_dac_code,
    output logic o_conv_end_irq
);
    // ************************************************************
    // declarations
    // ************************************************************
    // sequencer state and counters
    sas_pkg::sas_state_t st_reg;
    sas_pkg::sas_state_t st_next;
    logic [9:0] cnt_reg;
    logic [9:0] cnt_next;
    logic [5:0] step_reg;
    logic [5:0] step_next;
    logic [1:0] idx_reg;
    logic [1:0] idx_next;

    // control and status bits
    logic start_reg;
    logic start_next;
    logic flag_reg;
    logic flag_next;
    logic arm_reg;
    logic arm_next;
    logic [6:0] stat_ctl_reg;
    logic [6:0] stat_ctl_next;
    logic [2:0] trig_ctl_reg;
    logic [2:0] trig_ctl_next;

    // read path and results
    logic [7:0] temp_reg;
    logic [7:0] temp_next;
    logic [7:0] rdata_next;
    logic [RES_BITS-1:0] res_reg [NUM_RESULTS];

    // pin synchronisers
    logic trg_s1_reg;
    logic trg_s2_reg;
    logic trg_s3_reg;
    logic cmp_s1_reg;
    logic cmp_s2_reg;

    // approximation register
    logic sar_load;
    logic sar_step;
    logic [RES_BITS-1:0] sar_code;
    logic [2:0] chan_next;

    // ************************************************************
    // decode of the register port
    // ************************************************************
    // one strobe per cycle, never both
    wire wr_stat = i_wr && (i_addr == sas_pkg::SAS_IDX_CONV_CTRL_STATUS);
    wire wr_trig = i_wr && (i_addr == sas_pkg::SAS_IDX_TRIGGER_SCAN_CONTROL);
    wire rd_stat = i_rd && (i_addr == sas_pkg::SAS_IDX_CONV_CTRL_STATUS);
    wire rd_trig = i_rd && (i_addr == sas_pkg::SAS_IDX_TRIGGER_SCAN_CONTROL);
    // indices 0 to 7: four result pairs
    wire is_result = (i_addr[3] == sas_pkg::SAS_IDX_RESULT_HI_A[3]);
    wire rd_res_hi = i_rd && is_result && !i_addr[0];
    wire rd_res_lo = i_rd && is_result && i_addr[0];
    wire [1:0] res_sel = i_addr[2:1];

    // ************************************************************
    // mode fields
    // ************************************************************
    wire irq_en = stat_ctl_reg[sas_pkg::SAS_BIT_IRQ_ENABLE];
    wire multi = stat_ctl_reg[sas_pkg::SAS_BIT_MULTI];
    wire fast = stat_ctl_reg[sas_pkg::SAS_BIT_TIME_SELECT];
    wire [2:0] ch_sel = stat_ctl_reg[2:0];
    wire trig_en_hi = trig_ctl_reg[2];
    wire trig_en_lo = trig_ctl_reg[1];
    wire scan_select = trig_ctl_reg[0];
    // scan select needs multi set
    wire scan = multi && scan_select;
    // single mode ends at index zero
    wire [1:0] last_idx = multi ? ch_sel[1:0] : 2'h0;

    // ************************************************************
    // timing selected by the time select bit
    // ************************************************************
    // phases in states, one state a cycle
    wire [9:0] td_cnt = fast ? sas_pkg::SAS_TD_FAST : sas_pkg::SAS_TD_SLOW;
    wire [9:0] spl_cnt = fast ? sas_pkg::SAS_SPL_FAST : sas_pkg::SAS_SPL_SLOW;
    wire [9:0] conv_cnt = fast ? sas_pkg::SAS_CONV_FAST : sas_pkg::SAS_CONV_SLOW;
    wire [9:0] gap_cnt = fast ? sas_pkg::SAS_GAP_FAST : sas_pkg::SAS_GAP_SLOW;
    wire [5:0] step_cnt = fast ? sas_pkg::SAS_STEP_FAST : sas_pkg::SAS_STEP_SLOW;

    // start delay held at its minimum

    // ************************************************************
    // start, stop and end events
    // ************************************************************
    // trigger edge is looked at only past the second sync stage
    wire trig_fall = trg_s3_reg && !trg_s2_reg;
    // enables read live, change when idle
    wire trig_on = trig_en_hi && trig_en_lo;

    // a status write with start 0 stops
    wire sw_start = wr_stat && i_wdata[sas_pkg::SAS_BIT_START];
    wire sw_stop = wr_stat && !i_wdata[sas_pkg::SAS_BIT_START];
    // a start request while running is absorbed, never a restart
    wire go = !start_reg && (sw_start || (trig_fall && trig_on));

    // one down counter times every phase
    wire cnt_zero = (cnt_reg == 10'h000);
    // result and flag on the zero edge
    wire conv_end = (st_reg == sas_pkg::SAS_ST_CONVERT) && cnt_zero;
    wire seq_last = conv_end && (idx_reg == last_idx);
    // scan never halts on its own
    wire seq_halt = seq_last && !scan;
    // clear needs a read that saw the flag
    wire flag_clr = wr_stat && !i_wdata[sas_pkg::SAS_BIT_END_FLAG] && arm_reg;

    // ************************************************************
    // sequencer
    // ************************************************************
    always_comb begin
        st_next = st_reg;
        cnt_next = cnt_zero ? cnt_reg : (cnt_reg - 10'h001);
        idx_next = idx_reg;
        sar_load = 1'b0;
        unique case (st_reg)
            sas_pkg::SAS_ST_IDLE: begin
                // wait for a start
                if (go) begin
                    st_next = sas_pkg::SAS_ST_DELAY;
                    cnt_next = td_cnt - 10'h001;
                    idx_next = 2'h0;
                end
            end
            sas_pkg::SAS_ST_DELAY: begin
                // start delay
                if (cnt_zero) begin
                    st_next = sas_pkg::SAS_ST_SAMPLE;
                    cnt_next = spl_cnt - 10'h001;
                end
            end
            sas_pkg::SAS_ST_SAMPLE: begin
                // hold open, load at end
                if (cnt_zero) begin
                    st_next = sas_pkg::SAS_ST_CONVERT;
                    cnt_next = conv_cnt - 10'h001;
                    sar_load = 1'b1;
                end
            end
            sas_pkg::SAS_ST_CONVERT: begin
                // halt, or wrap in scan
                if (cnt_zero) begin
                    if (seq_halt) begin
                        st_next = sas_pkg::SAS_ST_IDLE;
                    end else begin
                        st_next = sas_pkg::SAS_ST_GAP;
                        cnt_next = gap_cnt - 10'h001;
                        idx_next = seq_last ? 2'h0 : (idx_reg + 2'h1);
                    end
                end
            end
            sas_pkg::SAS_ST_GAP: begin
                // pad to fixed length
                if (cnt_zero) begin
                    st_next = sas_pkg::SAS_ST_SAMPLE;
                    cnt_next = spl_cnt - 10'h001;
                end
            end
            default: begin
                // illegal code to idle
                st_next = sas_pkg::SAS_ST_IDLE;
            end
        endcase
        // a stopped conversion is lost
        if (sw_stop || i_standby) begin
            st_next = sas_pkg::SAS_ST_IDLE;
            idx_next = 2'h0;
        end
    end

    // approximation steps spaced evenly inside the convert phase
    assign sar_step = (st_reg == sas_pkg::SAS_ST_CONVERT) && (step_reg == 6'h00);
    assign step_next = (sar_load || sar_step) ? (step_cnt - 6'h01) :
                       ((step_reg == 6'h00) ? step_reg : (step_reg - 6'h01));
    // standby parks the channel at zero
    assign chan_next = i_standby ? 3'h0 :
                       multi ? {ch_sel[2], idx_next} : ch_sel;

    // ************************************************************
    // register next values
    // ************************************************************
    // standby and stop beat a start
    assign start_next = i_standby ? 1'b0 :
                        sw_stop ? 1'b0 :
                        go ? 1'b1 :
                        seq_halt ? 1'b0 : start_reg;

    // a completion in the clearing cycle keeps the flag set
    assign flag_next = i_standby ? 1'b0 :
                       seq_last ? 1'b1 :
                       flag_clr ? 1'b0 : flag_reg;

    // flag seen set by a status read
    assign arm_next = i_standby ? 1'b0 :
                      (rd_stat && flag_reg) ? 1'b1 :
                      flag_clr ? 1'b0 : arm_reg;
    // start lives in start_reg, bit 5 spare
    assign stat_ctl_next = i_standby ? sas_pkg::SAS_STATUS_RESET[6:0] :
                           wr_stat ? {i_wdata[6], 1'b0, i_wdata[4:0]} : stat_ctl_reg;
    assign trig_ctl_next = i_standby ? sas_pkg::SAS_TRIG_CTRL_RESET[7:5] :
                           wr_trig ? i_wdata[7:5] : trig_ctl_reg;

    assign temp_next = i_standby ? 8'h00 :
                       rd_res_hi ? {res_reg[res_sel][1:0], 6'h00} : temp_reg;

    // ************************************************************
    // read data, registered one cycle after the strobe
    // ************************************************************
    // fixed bits built, not stored
    wire [7:0] stat_rd = {flag_reg, irq_en, start_reg, multi, fast, ch_sel};
    wire [7:0] trig_rd = {trig_en_hi, trig_en_lo, scan_select, 2'h0,
                          sas_pkg::SAS_TRIG_CTRL_FIXED_ONES};
    // standby reads zero, as reset
    assign rdata_next = i_standby ? 8'h00 :
                        rd_res_hi ? res_reg[res_sel][9:2] :
                        rd_res_lo ? temp_reg :
                        rd_stat ? stat_rd :
                        rd_trig ? trig_rd : 8'h00;

    // ************************************************************
    // flip-flops
    // ************************************************************
    // pins pass two stages first
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            trg_s1_reg <= 1'b1;
            trg_s2_reg <= 1'b1;
            trg_s3_reg <= 1'b1;
            cmp_s1_reg <= 1'b0;
            cmp_s2_reg <= 1'b0;
        end else begin
            trg_s1_reg <= i_ext_trigger_n;
            trg_s2_reg <= trg_s1_reg;
            // edge detector stage
            trg_s3_reg <= trg_s2_reg;
            cmp_s1_reg <= i_cmp_above;
            cmp_s2_reg <= cmp_s1_reg;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st_reg <= sas_pkg::SAS_ST_IDLE;
            cnt_reg <= 10'h000;
            step_reg <= 6'h00;
            idx_reg <= 2'h0;
            o_chan <= 3'h0;
            o_sample_hold <= 1'b0;
        end else begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            step_reg <= step_next;
            idx_reg <= idx_next;
            o_chan <= chan_next;
            // follows next state, no lag
            o_sample_hold <= (st_next == sas_pkg::SAS_ST_SAMPLE);
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            start_reg <= 1'b0;
            flag_reg <= 1'b0;
            arm_reg <= 1'b0;
            stat_ctl_reg <= sas_pkg::SAS_STATUS_RESET[6:0];
            trig_ctl_reg <= sas_pkg::SAS_TRIG_CTRL_RESET[7:5];
            temp_reg <= 8'h00;
            o_rdata <= 8'h00;
            o_conv_end_irq <= 1'b0;
        end else begin
            start_reg <= start_next;
            flag_reg <= flag_next;
            arm_reg <= arm_next;
            stat_ctl_reg <= stat_ctl_next;
            trig_ctl_reg <= trig_ctl_next;
            temp_reg <= temp_next;
            o_rdata <= rdata_next;
            // rises on the flag's edge
            o_conv_end_irq <= flag_next && stat_ctl_next[sas_pkg::SAS_BIT_IRQ_ENABLE];
        end
    end

    // result written in every completion cycle, flag rises the same edge only for the last of a sequence
    // a stopped conversion writes nothing
    generate
        for (genvar k = 0; k < NUM_RESULTS; k++) begin : g_res
            always_ff @(posedge i_clk or posedge i_sys_rst) begin
                if (i_sys_rst) begin
                    res_reg[k] <= sas_pkg::SAS_RESULT_RESET;
                end else if (i_standby) begin
                    res_reg[k] <= sas_pkg::SAS_RESULT_RESET;
                end else if (conv_end && (o_chan[1:0] == 2'(k))) begin
                    res_reg[k] <= sar_code;
                end
            end
        end
    endgenerate

    // ************************************************************
    // approximation register
    // ************************************************************
    // comparator decision two cycles late
    sas_sar_trial #(
        .WIDTH(RES_BITS)
    ) u_sar (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_load(sar_load),
        .i_step(sar_step),
        .i_keep(cmp_s2_reg),
        .o_code(sar_code),
        .o_done()
    );
    // code straight from the sar flops
    assign o_dac_code = sar_code;

endmodule
`default_nettype wire

// [pkg/sas_pkg.sv]
// package: constants, register map and state type for the converter sequencer
// assumes one peripheral clock state equals one i_clk cycle unless
// SAS_CLK_PER_STATE is changed
package sas_pkg;

    // ************************************************************
    // register indices on the peripheral port
    // ************************************************************
    localparam logic [3:0] SAS_IDX_RESULT_HI_A = 4'h0;
    localparam logic [3:0] SAS_IDX_CONV_CTRL_STATUS = 4'h8;
    localparam logic [3:0] SAS_IDX_TRIGGER_SCAN_CONTROL = 4'h9;

    // ************************************************************
    // field positions and reset values
    // ************************************************************
    localparam int SAS_BIT_END_FLAG = 7;
    localparam int SAS_BIT_IRQ_ENABLE = 6;
    localparam int SAS_BIT_START = 5;
    localparam int SAS_BIT_MULTI = 4;
    localparam int SAS_BIT_TIME_SELECT = 3;
    localparam int SAS_BIT_TRIG_EN_HI = 7;
    localparam int SAS_BIT_TRIG_EN_LO = 6;
    localparam int SAS_BIT_SCAN_SELECT = 5;
    localparam logic [7:0] SAS_STATUS_RESET = 8'h00;
    localparam logic [7:0] SAS_TRIG_CTRL_RESET = 8'h07;
    localparam logic [2:0] SAS_TRIG_CTRL_FIXED_ONES = 3'h7;
    localparam logic [9:0] SAS_RESULT_RESET = 10'h000;

    // ************************************************************
    // timing in states, and cycle counts derived from it
    // ************************************************************
    localparam int SAS_CLK_PER_STATE = 1;
    localparam int SAS_TD_SLOW_STATES = 17;
    localparam int SAS_TD_FAST_STATES = 10;
    localparam int SAS_SPL_SLOW_STATES = 129;
    localparam int SAS_SPL_FAST_STATES = 65;
    localparam int SAS_FIRST_SLOW_STATES = 514;
    localparam int SAS_FIRST_FAST_STATES = 259;
    localparam int SAS_NEXT_SLOW_STATES = 512;
    localparam int SAS_NEXT_FAST_STATES = 256;
    localparam int SAS_STEP_SLOW_STATES = 36;
    localparam int SAS_STEP_FAST_STATES = 18;
    // approximation phase is what is left of the first conversion
    localparam logic [9:0] SAS_TD_SLOW = 10'(SAS_TD_SLOW_STATES * SAS_CLK_PER_STATE);
    localparam logic [9:0] SAS_TD_FAST = 10'(SAS_TD_FAST_STATES * SAS_CLK_PER_STATE);
    localparam logic [9:0] SAS_SPL_SLOW = 10'(SAS_SPL_SLOW_STATES * SAS_CLK_PER_STATE);
    localparam logic [9:0] SAS_SPL_FAST = 10'(SAS_SPL_FAST_STATES * SAS_CLK_PER_STATE);
    localparam logic [9:0] SAS_CONV_SLOW =
        10'((SAS_FIRST_SLOW_STATES - SAS_TD_SLOW_STATES - SAS_SPL_SLOW_STATES) * SAS_CLK_PER_STATE);
    localparam logic [9:0] SAS_CONV_FAST =
        10'((SAS_FIRST_FAST_STATES - SAS_TD_FAST_STATES - SAS_SPL_FAST_STATES) * SAS_CLK_PER_STATE);
    // recovery gap pads each later conversion to its fixed length
    localparam logic [9:0] SAS_GAP_SLOW =
        10'((SAS_NEXT_SLOW_STATES - SAS_FIRST_SLOW_STATES + SAS_TD_SLOW_STATES) * SAS_CLK_PER_STATE);
    localparam logic [9:0] SAS_GAP_FAST =
        10'((SAS_NEXT_FAST_STATES - SAS_FIRST_FAST_STATES + SAS_TD_FAST_STATES) * SAS_CLK_PER_STATE);
    localparam logic [5:0] SAS_STEP_SLOW = 6'(SAS_STEP_SLOW_STATES * SAS_CLK_PER_STATE);
    localparam logic [5:0] SAS_STEP_FAST = 6'(SAS_STEP_FAST_STATES * SAS_CLK_PER_STATE);

    // ************************************************************
    // sequencer states, gray along idle-delay-sample-convert-gap
    // ************************************************************
    typedef enum logic [2:0] {
        SAS_ST_IDLE = 3'h0,
        SAS_ST_DELAY = 3'h1,
        SAS_ST_SAMPLE = 3'h3,
        SAS_ST_CONVERT = 3'h2,
        SAS_ST_GAP = 3'h6
    } sas_state_t;

endpackage

// [verilog/sas_sar_trial.sv]
// module: successive approximation register, one bit decided per step
// assumes i_keep is already in the i_clk domain and settled at each step
`timescale 1ns/1ps
`default_nettype none
module sas_sar_trial #(
    parameter int WIDTH = 10
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_load,
    input wire logic i_step,
    input wire logic i_keep,
    output logic [WIDTH-1:0] o_code,
    output logic o_done
);
    logic [WIDTH-1:0] mask_reg;
    logic [WIDTH-1:0] mask_next;
    logic [WIDTH-1:0] code_next;
    logic [WIDTH-1:0] trial_bit;

    assign trial_bit = {1'b1, {(WIDTH-1){1'b0}}};
    // a dropped trial bit is cleared, the next lower one is tried
    assign mask_next = i_load ? trial_bit : (i_step ? (mask_reg >> 1) : mask_reg);
    assign code_next = i_load ? trial_bit :
                       (i_step && mask_reg != '0) ? ((i_keep ? o_code : (o_code & ~mask_reg)) | (mask_reg >> 1)) :
                       o_code;

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            mask_reg <= '0;
            o_code <= '0;
            o_done <= 1'b1;
        end else begin
            mask_reg <= mask_next;
            o_code <= code_next;
            o_done <= (mask_next == '0);
        end
    end
endmodule
`default_nettype wire

// [dv/sas_sequencer_props.sv]
// checker: port-level assertions for the converter sequencer top
// assumes the register indices and timing constants of the sequencer package
`timescale 1ns/1ps
`default_nettype none
module sas_sequencer_chk #(
    parameter int RES_BITS = 10,
    parameter int NUM_RESULTS = 4
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_standby,
    input wire logic [3:0] i_addr,
    input wire logic i_rd,
    input wire logic i_wr,
    input wire logic [7:0] i_wdata,
    input wire logic [7:0] o_rdata,
    input wire logic i_ext_trigger_n,
    input wire logic i_cmp_above,
    input wire logic o_sample_hold,
    input wire logic [2:0] o_chan,
    input wire logic [RES_BITS-1:0] o_dac_code,
    input wire logic o_conv_end_irq
);
    // ************************************************************
    // sampling window length, saturating
    // ************************************************************
    logic [9:0] hold_cnt_reg;
    logic [9:0] hold_cnt_next;
    assign hold_cnt_next = !o_sample_hold ? 10'h000 : (hold_cnt_reg == 10'h3ff) ? hold_cnt_reg : hold_cnt_reg + 10'h001;
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            hold_cnt_reg <= 10'h000;
        end else begin
            hold_cnt_reg <= hold_cnt_next;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    // a stop write or standby cuts a window short, so those are excused
    sequence s_natural_end;
        $fell(o_sample_hold) && !$past(i_wr) && !$past(i_wr, 2) && !$past(i_standby) && !$past(i_standby, 2);
    endsequence
    sequence s_trig_rd;
        i_rd && i_addr == 4'h9;
    endsequence
    sequence s_standby_held;
        i_standby ##1 i_standby;
    endsequence
    sample_len_a: assert property (s_natural_end |-> hold_cnt_reg == 10'h081 || hold_cnt_reg == 10'h041)
        else $error("sampling window length wrong");
    trig_fixed_a: assert property (s_trig_rd |=> o_rdata[4:0] == 5'h07)
        else $error("trigger control low bits wrong");
    lo_zero_a: assert property (i_rd && i_addr < 4'h8 && i_addr[0] |=> o_rdata[5:0] == 6'h00)
        else $error("result low byte spare bits not zero");
    unmapped_a: assert property (i_rd && i_addr > 4'h9 |=> o_rdata == 8'h00)
        else $error("unmapped read not zero");
    rd_idle_a: assert property (!i_rd |=> o_rdata == 8'h00)
        else $error("read data without a read");
    irq_clear_a: assert property ($fell(o_conv_end_irq) |-> $past(i_wr) || $past(i_wr, 2) || $past(i_standby))
        else $error("interrupt dropped without a write");
    standby_a: assert property (s_standby_held |-> !o_sample_hold && !o_conv_end_irq && o_chan == 3'h0)
        else $error("standby did not stop conversion");
    chan_hold_a: assert property (o_sample_hold && $past(o_sample_hold) |-> o_chan == $past(o_chan))
        else $error("channel moved while sampling");
endmodule
bind sas_sequencer sas_sequencer_chk #(.RES_BITS(RES_BITS), .NUM_RESULTS(NUM_RESULTS)) i_chk (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_standby(i_standby), .i_addr(i_addr), .i_rd(i_rd),
    .i_wr(i_wr), .i_wdata(i_wdata), .o_rdata(o_rdata), .i_ext_trigger_n(i_ext_trigger_n),
    .i_cmp_above(i_cmp_above), .o_sample_hold(o_sample_hold), .o_chan(o_chan),
    .o_dac_code(o_dac_code), .o_conv_end_irq(o_conv_end_irq));
`default_nettype wire

// [dv/sas_analog_model.sv]
// model: sample-and-hold plus comparator on the analog side
// assumes eight fixed input levels given by the bench, ten bits each
`timescale 1ns/1ps
`default_nettype none
module sas_analog_model (
    input wire logic i_clk,
    input wire logic [2:0] i_chan,
    input wire logic [9:0] i_dac_code,
    input wire logic i_sample_hold,
    input wire logic [79:0] i_levels,
    output logic o_cmp_above
);
    logic [9:0] held_reg = 10'h000;
    // held value follows the selected input only while sampling
    always_ff @(posedge i_clk) begin
        if (i_sample_hold) begin
            held_reg <= i_levels[i_chan*10 +: 10];
        end
    end
    // level plus half an lsb, so a tie never depends on strict compare
    assign o_cmp_above = ({held_reg, 1'b1} > {i_dac_code, 1'b0});
endmodule
`default_nettype wire

// [dv/tb_sas_sequencer.sv]
// bench: self-checking run of the sequencer top with an analog model
// assumes sas_analog_model and the bound checker are compiled alongside
`timescale 1ns/1ps
`default_nettype none
module tb_sas_sequencer;
    logic i_clk, i_sys_rst, i_standby, i_rd, i_wr, i_ext_trigger_n, cmp_above, sample_hold, irq;
    logic [3:0] i_addr;
    logic [7:0] i_wdata, rdata;
    logic [2:0] chan;
    logic [9:0] dac_code;
    logic [79:0] levels;
    int n_mismatch = 0;
    int samples_checked = 0;
    int seed = 32'h0e25;
    int n;
    sas_sequencer i_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_standby(i_standby), .i_addr(i_addr),
        .i_rd(i_rd), .i_wr(i_wr), .i_wdata(i_wdata), .o_rdata(rdata), .i_ext_trigger_n(i_ext_trigger_n),
        .i_cmp_above(cmp_above), .o_sample_hold(sample_hold), .o_chan(chan), .o_dac_code(dac_code),
        .o_conv_end_irq(irq));
    sas_analog_model i_ana (.i_clk(i_clk), .i_chan(chan), .i_dac_code(dac_code),
        .i_sample_hold(sample_hold), .i_levels(levels), .o_cmp_above(cmp_above));
    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end
    // ************************************************************
    // checking and bus tasks
    // ************************************************************
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge i_clk);
        i_wr = 1'b1;
        i_addr = a;
        i_wdata = d;
        @(negedge i_clk);
        i_wr = 1'b0;
    endtask
    task automatic chk_rd(input string what, input logic [3:0] a, input logic [7:0] exp);
        @(negedge i_clk);
        i_rd = 1'b1;
        i_addr = a;
        @(negedge i_clk);
        i_rd = 1'b0;
        check(what, rdata, exp);
    endtask
    task automatic wait_irq(input int lim, output int cnt);
        cnt = 0;
        while (irq !== 1'b1 && cnt < lim) begin
            @(negedge i_clk);
            cnt++;
        end
        if (cnt >= lim) begin
            n_mismatch++;
            $display("[FAIL] irq wait expected 1 seen 0");
            end_sim();
        end
    endtask
    task automatic pulse_trig;
        @(negedge i_clk);
        i_ext_trigger_n = 1'b0;
        repeat (4) @(negedge i_clk);
        i_ext_trigger_n = 1'b1;
    endtask
    function automatic logic [7:0] lvl_hi(input int ch);
        return levels[ch*10+2 +: 8];
    endfunction
    function automatic logic [7:0] lvl_lo(input int ch);
        return {levels[ch*10 +: 2], 6'h00};
    endfunction
    task automatic chk_res(input int ch, input int slot);
        chk_rd("result hi", 4'(2*slot), lvl_hi(ch));
        chk_rd("result lo", 4'(2*slot+1), lvl_lo(ch));
    endtask
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        i_sys_rst = 1'b1; i_standby = 1'b0; i_addr = 4'h0; i_rd = 1'b0; i_wr = 1'b0;
        i_wdata = 8'h00; i_ext_trigger_n = 1'b1;
        for (int k = 0; k < 8; k++) levels[k*10 +: 10] = 10'($random(seed));
        levels[9:0] = 10'h3ff;
        levels[49:40] = 10'h000;
        repeat (4) @(negedge i_clk);
        i_sys_rst = 1'b0;
        chk_rd("status", 4'h8, 8'h00);
        chk_rd("trig ctrl", 4'h9, 8'h07);
        chk_rd("result a hi", 4'h0, 8'h00);
        wr(4'h9, 8'hff);
        chk_rd("trig ctrl", 4'h9, 8'he7);
        wr(4'h9, 8'h00);
        chk_rd("trig ctrl", 4'h9, 8'h07);
        wr(4'hc, 8'hff);
        chk_rd("unmapped", 4'hc, 8'h00);
        wr(4'h8, 8'h61);
        wait_irq(600, n);
        check("slow single time", 8'(n >= 514 && n <= 526), 8'h01);
        chk_rd("status", 4'h8, 8'hc1);
        chk_res(1, 1);
        wr(4'h8, 8'h41);
        chk_rd("status", 4'h8, 8'h41);
        check("irq", {7'h00, irq}, 8'h00);
        wr(4'h8, 8'h68);
        wait_irq(300, n);
        check("fast single time", 8'(n >= 259 && n <= 267), 8'h01);
        chk_res(0, 0);
        // flag set but not yet read as one, so a zero write must not clear it
        wr(4'h8, 8'h48);
        chk_rd("status", 4'h8, 8'hc8);
        wr(4'h8, 8'h48);
        chk_rd("status", 4'h8, 8'h48);
        wr(4'h8, 8'h7e);
        wait_irq(900, n);
        check("multi time", 8'(n >= 771 && n <= 779), 8'h01);
        chk_rd("status", 4'h8, 8'hde);
        for (int k = 0; k < 3; k++) chk_res(4 + k, k);
        chk_rd("stale lo", 4'h1, lvl_lo(6));
        wr(4'h8, 8'h5e);
        for (int k = 0; k < 3; k++) begin
            wr(4'h9, 8'(k << 6));
            pulse_trig();
            repeat (30) @(negedge i_clk);
            chk_rd("no trigger start", 4'h8, 8'h5e);
        end
        wr(4'h9, 8'he0);
        wr(4'h8, 8'h51);
        pulse_trig();
        wait_irq(1200, n);
        chk_rd("scan status", 4'h8, 8'hf1);
        chk_res(0, 0);
        chk_res(1, 1);
        wr(4'h8, 8'h71);
        wait_irq(1100, n);
        chk_rd("scan status", 4'h8, 8'hf1);
        wr(4'h8, 8'h51);
        repeat (600) @(negedge i_clk);
        chk_rd("scan stopped", 4'h8, 8'h51);
        check("irq after stop", {7'h00, irq}, 8'h00);
        wr(4'h8, 8'h21);
        repeat (40) @(negedge i_clk);
        i_standby = 1'b1;
        repeat (3) @(negedge i_clk);
        i_standby = 1'b0;
        chk_rd("status", 4'h8, 8'h00);
        chk_rd("trig ctrl", 4'h9, 8'h07);
        end_sim();
    end
endmodule
`default_nettype wire
